// *** sim/occ_console_chk.sv ***
`timescale 1ns/1ps
module occ_console_chk
	import occ_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [15:0] data_sw_i,
	input wire logic        key_lock_i,
	input wire logic        sw_examine_i,
	input wire logic        sw_start_i,
	input wire logic [15:0] sw_rd_data_o,
	input wire logic        cpu_cycle_done_i,
	input wire logic        mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	input wire logic        cpu_run_o,
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic [14:0] mem_addr_o,
	input wire logic [15:0] mem_wdata_o,
	input wire logic        dev_rd_o,
	input wire logic        dev_start_in_o,
	input wire logic        io_reset_o,
	input wire logic        intr_en_clear_o,
	input wire logic        supervisor_o,
	input wire logic        rtc_line_o,
	input wire logic [15:0] lamp_data_o,
	input wire logic [4:0]  lamp_state_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_mem_done(logic we);
		mem_req_o && mem_we_o == we && mem_ack_i;
	endsequence
	sequence s_chan_wr;
		mem_req_o && mem_we_o && mem_addr_o == CHAN_ADDR
			&& mem_wdata_o == JUMP_SELF_WORD;
	endsequence

	switch_read_a: assert property (
		!$past(rst_i) && $stable(data_sw_i) |-> sw_rd_data_o == data_sw_i)
		else $error("switch read path wrong");
	lock_ignore_a: assert property (
		$rose(sw_examine_i) && key_lock_i |=> (!mem_req_o)[*6])
		else $error("locked console acted");
	state_onehot_a: assert property (
		!$past(rst_i) |-> $onehot(lamp_state_o))
		else $error("state lamps not one-hot");
	run_interlock_a: assert property (
		cpu_run_o |-> !mem_req_o)
		else $error("console memory access while running");
	read_lamp_a: assert property (
		s_mem_done(1'b0) |=> lamp_data_o == $past(mem_rdata_i) && !mem_req_o)
		else $error("read word not shown");
	write_lamp_a: assert property (
		s_mem_done(1'b1) |=> lamp_data_o == $past(mem_wdata_o))
		else $error("written word not shown");
	start_run_a: assert property (
		$rose(sw_start_i) && !key_lock_i && !cpu_run_o && !mem_req_o
			&& !dev_rd_o |-> ##[2:6] cpu_run_o)
		else $error("start did not run");
	halt_edge_a: assert property (
		$fell(cpu_run_o) |-> $past(cpu_cycle_done_i)
			|| $past(cpu_cycle_done_i, 2))
		else $error("halt not at cycle end");
	reset_pulse_a: assert property (
		io_reset_o |-> (intr_en_clear_o && supervisor_o && rtc_line_o)
			##1 !io_reset_o)
		else $error("reset outputs not one pulse");
	chan_store_a: assert property (
		$rose(dev_start_in_o) |-> ##[0:8] s_chan_wr)
		else $error("jump-to-self not stored");
endmodule // occ_console_chk

bind occ_console occ_console_chk occ_console_chk_i (.*);

// *** sim/occ_console_tb.sv ***
`timescale 1ns/1ps
module occ_console_tb
	import occ_pkg::*;
;
	logic              clk_i, rst_i, psel_i, penable_i, pwrite_i, err;
	logic              pready_o, pslverr_o, key_lock_i, cpu_run_o, ac_we_o;
	logic              cpu_cycle_done_i, cpu_instr_done_i, dev_ready_i;
	logic              mem_req_o, mem_we_o, mem_ack_i, dev_rd_o;
	logic              io_reset_o, intr_en_clear_o, supervisor_o, rtc_line_o;
	logic              lamp_run_o, lamp_intr_en_o, dev_start_in_o;
	logic [11:0]       paddr_i;
	logic [31:0]       pwdata_i, prdata_o, rd;
	logic [15:0]       data_sw_i, sw_rd_data_o, cpu_instr_i, ac_wdata_o;
	logic [15:0]       mem_wdata_o, mem_rdata_i, dev_data_i, lamp_data_o;
	logic [14:0]       cpu_pc_i, cpu_pc_o, mem_addr_o, lamp_addr_o;
	logic [1:0]        ac_wsel_o, ac_rsel_o;
	logic [5:0]        dev_code_o, start_code;
	logic [4:0]        rom_addr_o, lamp_state_o;
	logic [7:0]        lamp_instr_o;
	logic [17:0]       ac_last;
	logic [SW_COUNT-1:0] sw_q;
	occ_cycle_e        cpu_next_state_i, cpu_state_o;
	int                mismatches, comparisons, ac_n, rst_n, dev_n;

	wire [3:0]  sw_ac_dep_i = sw_q[SW_AC_DEP+:4];
	wire [3:0]  sw_ac_exam_i = sw_q[SW_AC_EXAM+:4];
	wire        sw_examine_i = sw_q[SW_EXAMINE], sw_deposit_i = sw_q[SW_DEPOSIT];
	wire        sw_exam_next_i = sw_q[SW_EXAM_NEXT];
	wire        sw_dep_next_i = sw_q[SW_DEP_NEXT], sw_start_i = sw_q[SW_START];
	wire        sw_stop_i = sw_q[SW_STOP], sw_continue_i = sw_q[SW_CONTINUE];
	wire        sw_instr_adv_i = sw_q[SW_INSTR_ADV];
	wire        sw_mem_step_i = sw_q[SW_MEM_STEP], sw_reset_i = sw_q[SW_RESET];
	wire        sw_prog_load_i = sw_q[SW_PROG_LOAD];
	wire        sw_chan_start_i = sw_q[SW_CHAN_START];
	wire [15:0] ac_rdata_i = {14'h1DC0, ac_rsel_o};
	wire [14:0] cpu_next_addr_i = 15'h0000;
	wire        cpu_is_jsr_i = 1'b0, intr_en_i = 1'b0;
	wire [15:0] cpu_mem_data_i = 16'h0000, rom_data_i = 16'h0000;

	occ_console occ_console_i (.*);
	occ_mem_model occ_mem_model_i (.clk_i(clk_i), .rst_i(rst_i),
		.mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Event monitor and boot device answering each read request
	always @(posedge clk_i)
	begin
		if (ac_we_o === 1'b1)
		begin
			ac_n++;
			ac_last = {ac_wsel_o, ac_wdata_o};
		end
		if (io_reset_o === 1'b1)
			rst_n++;
		if (dev_start_in_o === 1'b1)
			start_code = dev_code_o;
		dev_ready_i <= dev_rd_o && !dev_ready_i;
		dev_data_i <= (dev_rd_o && !dev_ready_i) ? 16'h3000 + 16'(dev_n)
			: ~dev_data_i;
		if (dev_ready_i)
			dev_n++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		paddr_i <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic press(input int i);
		int n;
		n = 0;
		@(posedge clk_i);
		sw_q[i] <= 1'b1;
		repeat (5) @(posedge clk_i);
		sw_q[i] <= 1'b0;
		while ((mem_req_o || dev_rd_o) && n++ < 100) @(posedge clk_i);
		repeat (3) @(posedge clk_i);
	endtask

	task automatic cyc(input occ_cycle_e s, input logic d);
		@(posedge clk_i);
		cpu_cycle_done_i <= 1'b1;
		cpu_instr_done_i <= d;
		cpu_next_state_i <= s;
		@(posedge clk_i);
		cpu_cycle_done_i <= 1'b0;
		cpu_instr_done_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic wait_run;
		int n;
		n = 0;
		while (cpu_run_o !== 1'b1 && n++ < 2000) @(posedge clk_i);
	endtask

	task automatic summarize;
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		summarize();
	end

	initial
	begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, sw_q} = '0;
		{key_lock_i, cpu_cycle_done_i, cpu_instr_done_i, dev_ready_i} = '0;
		{data_sw_i, cpu_instr_i, cpu_pc_i, dev_data_i} = '0;
		{ac_n, rst_n, dev_n, mismatches, comparisons} = '0;
		cpu_next_state_i = CYC_FETCH;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		chk(rd[7:0], 8'h01);
		apb(1'b0, REG_CTRL, 32'h0000_0000);
		chk(rd, CTRL_RESET);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({err, rd[15:0]}, 17'h1_0000);
		data_sw_i <= 16'h0040;
		press(SW_EXAMINE);
		chk(sw_rd_data_o, 16'h0040);
		chk(lamp_addr_o, 15'h0040);
		chk(lamp_data_o, 16'h0040 ^ 16'hC3C3);
		data_sw_i <= 16'hBEEF;
		press(SW_DEPOSIT);
		chk(occ_mem_model_i.mem[15'h0040], 16'hBEEF);
		press(SW_EXAM_NEXT);
		chk(lamp_addr_o, 15'h0041);
		chk(lamp_data_o, 16'h0041 ^ 16'hC3C3);
		press(SW_DEP_NEXT);
		chk(occ_mem_model_i.mem[15'h0042], 16'hBEEF);
		chk({lamp_addr_o, lamp_data_o}, {15'h0042, 16'hBEEF});
		data_sw_i <= 16'h5A5A;
		press(SW_AC_DEP + 2);
		chk({lamp_instr_o, lamp_data_o}, 24'h00_5A5A);
		chk(ac_n, 0);
		press(SW_AC_EXAM + 1);
		chk(ac_last, {2'd2, 16'h5A5A});
		chk(lamp_data_o, 16'h7701);
		data_sw_i <= 16'h1111;
		press(SW_AC_DEP + 3);
		press(SW_RESET);
		chk(rst_n, 1);
		key_lock_i <= 1'b1;
		data_sw_i <= 16'h0055;
		press(SW_EXAMINE);
		chk(lamp_addr_o, 15'h0042);
		chk(sw_rd_data_o, 16'h0055);
		key_lock_i <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		press(SW_EXAMINE);
		chk(lamp_addr_o, 15'h0042);
		apb(1'b1, REG_CTRL, CTRL_RESET);
		data_sw_i <= 16'h0100;
		press(SW_START);
		chk({cpu_run_o, cpu_pc_o}, {1'b1, 15'h0100});
		chk(cpu_state_o, CYC_FETCH);
		chk(ac_n, 1);
		press(SW_EXAMINE);
		chk(cpu_pc_o, 15'h0100);
		cpu_instr_i <= 16'hA3C0;
		cpu_pc_i <= 15'h0101;
		cyc(CYC_EXECUTE, 1'b0);
		press(SW_STOP);
		chk(cpu_run_o, 1'b1);
		cyc(CYC_FETCH, 1'b1);
		chk(cpu_run_o, 1'b0);
		chk(lamp_instr_o, 8'hA3);
		chk({lamp_addr_o, lamp_state_o}, {15'h0101, 5'h01});
		press(SW_INSTR_ADV);
		cyc(CYC_EXECUTE, 1'b0);
		chk(cpu_run_o, 1'b1);
		cyc(CYC_FETCH, 1'b1);
		chk(cpu_run_o, 1'b0);
		press(SW_MEM_STEP);
		cyc(CYC_INDIRECT, 1'b0);
		chk({cpu_run_o, lamp_state_o}, {1'b0, 5'h02});
		press(SW_CONTINUE);
		chk(cpu_run_o, 1'b1);
		chk(cpu_state_o, CYC_INDIRECT);
		press(SW_STOP);
		cyc(CYC_INTR, 1'b0);
		cyc(CYC_FETCH, 1'b0);
		chk({cpu_run_o, lamp_instr_o}, 9'h000);
		press(SW_CONTINUE);
		press(SW_RESET);
		cyc(CYC_EXECUTE, 1'b0);
		chk({cpu_run_o, rst_n[3:0]}, {1'b0, 4'h2});
		data_sw_i <= 16'h000D;
		press(SW_CHAN_START);
		wait_run();
		chk(start_code, 6'h0D);
		chk(occ_mem_model_i.mem[CHAN_ADDR], JUMP_SELF_WORD);
		chk(cpu_pc_o, CHAN_ADDR);
		press(SW_RESET);
		cyc(CYC_FETCH, 1'b0);
		press(SW_PROG_LOAD);
		wait_run();
		chk(occ_mem_model_i.mem[15'h0000], 16'h3000);
		chk(occ_mem_model_i.mem[15'h0020], 16'h3020);
		chk(occ_mem_model_i.mem[15'h0021], 16'h0021 ^ 16'hC3C3);
		chk({cpu_pc_o, dev_n[7:0]}, {15'h0020, 8'd33});
		summarize();
	end
endmodule // occ_console_tb

// *** sim/occ_mem_model.sv ***
`timescale 1ns/1ps
module occ_mem_model
#(
	parameter int DLY = 2
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        mem_req_i,
	input  wire logic        mem_we_i,
	input  wire logic [14:0] mem_addr_i,
	input  wire logic [15:0] mem_wdata_i,
	output logic             mem_ack_o,
	output logic [15:0]      mem_rdata_o
);
	logic [15:0] mem [0:32767];
	int          cnt;

	// Known fill pattern, so stale reads are easy to spot
	initial
	begin
		for (int i = 0; i < 32768; i++)
			mem[i] = 16'(i) ^ 16'hC3C3;
		mem_ack_o = 1'b0;
		mem_rdata_o = 16'h0000;
		cnt = 0;
	end

	// Answers after a delay; read data wanders when not acked
	always @(posedge clk_i)
	begin
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (rst_i || !mem_req_i || mem_ack_o)
			cnt <= 0;
		else if (cnt < DLY)
			cnt <= cnt + 1;
		else
		begin
			mem_ack_o <= 1'b1;
			cnt <= 0;
			if (mem_we_i)
				mem[mem_addr_i] <= mem_wdata_i;
			else
				mem_rdata_o <= mem[mem_addr_i];
		end
	end
endmodule // occ_mem_model

// *** verilog/occ_console.sv ***
`timescale 1ns/1ps
module occ_console
	import occ_pkg::*;
#(
	parameter bit FAST_MODEL   = 1'b0,
	parameter bit HAS_BOOT_ROM = 1'b0
)(
	input  logic                 clk_i,
	input  logic                 rst_i,
	input  logic [11:0]          paddr_i,
	input  logic                 psel_i,
	input  logic                 penable_i,
	input  logic                 pwrite_i,
	input  logic [31:0]          pwdata_i,
	output logic [31:0]          prdata_o,
	output logic                 pready_o,
	output logic                 pslverr_o,
	input  logic [15:0]          data_sw_i,
	input  logic                 key_lock_i,
	input  logic [NUM_AC-1:0]    sw_ac_dep_i,
	input  logic [NUM_AC-1:0]    sw_ac_exam_i,
	input  logic                 sw_examine_i,
	input  logic                 sw_deposit_i,
	input  logic                 sw_exam_next_i,
	input  logic                 sw_dep_next_i,
	input  logic                 sw_start_i,
	input  logic                 sw_stop_i,
	input  logic                 sw_continue_i,
	input  logic                 sw_instr_adv_i,
	input  logic                 sw_mem_step_i,
	input  logic                 sw_reset_i,
	input  logic                 sw_prog_load_i,
	input  logic                 sw_chan_start_i,
	output logic [15:0]          sw_rd_data_o,
	input  logic                 cpu_cycle_done_i,
	input  logic                 cpu_instr_done_i,
	input  occ_cycle_e           cpu_next_state_i,
	input  logic [15:0]          cpu_instr_i,
	input  logic [15:0]          cpu_mem_data_i,
	input  logic [14:0]          cpu_next_addr_i,
	input  logic [14:0]          cpu_pc_i,
	input  logic                 cpu_is_jsr_i,
	input  logic                 intr_en_i,
	output logic                 cpu_run_o,
	output occ_cycle_e           cpu_state_o,
	output logic [14:0]          cpu_pc_o,
	output logic                 ac_we_o,
	output logic [1:0]           ac_wsel_o,
	output logic [15:0]          ac_wdata_o,
	output logic [1:0]           ac_rsel_o,
	input  logic [15:0]          ac_rdata_i,
	output logic                 mem_req_o,
	output logic                 mem_we_o,
	output logic [14:0]          mem_addr_o,
	output logic [15:0]          mem_wdata_o,
	input  logic                 mem_ack_i,
	input  logic [15:0]          mem_rdata_i,
	output logic                 dev_rd_o,
	output logic                 dev_start_in_o,
	output logic [5:0]           dev_code_o,
	input  logic                 dev_ready_i,
	input  logic [15:0]          dev_data_i,
	output logic [4:0]           rom_addr_o,
	input  logic [15:0]          rom_data_i,
	output logic                 io_reset_o,
	output logic                 intr_en_clear_o,
	output logic                 supervisor_o,
	output logic                 rtc_line_o,
	output logic [14:0]          lamp_addr_o,
	output logic [15:0]          lamp_data_o,
	output logic [7:0]           lamp_instr_o,
	output logic [4:0]           lamp_state_o,
	output logic                 lamp_run_o,
	output logic                 lamp_intr_en_o
);

	typedef enum logic [2:0] {
		C_IDLE,
		C_ACRD,
		C_MEM,
		C_BOOT_SRC,
		C_BOOT_WR,
		C_CHAN_CMD,
		C_CHAN_WR
	} occ_con_e;

	logic [SW_COUNT-1:0] sw_raw;
	logic [SW_COUNT-1:0] sw_meta_q;
	logic [SW_COUNT-1:0] sw_sync_q;
	logic [SW_COUNT-1:0] sw_prev_q;
	logic [SW_COUNT-1:0] press;
	logic                enabled;
	logic                idle;
	logic                stop_p;
	logic                reset_p;
	logic                dep_hit;
	logic                exam_hit;
	logic [1:0]          dep_idx;
	logic [1:0]          exam_idx;
	logic                any_go;
	logic                boot_done;
	logic                chan_done;
	logic                run_go;
	logic                halt_now;
	logic [5:0]          boot_last;
	occ_con_e            con_q;
	occ_cycle_e          state_q;
	logic                run_q;
	logic                stop_pend_q;
	logic                cyc_step_q;
	logic                serviced_q;
	logic [31:0]         ctrl_q;
	logic [14:0]         pc_q;
	logic [14:0]         instr_pc_q;
	logic [15:0]         lamp_data_q;
	logic [7:0]          lamp_instr_q;
	logic [4:0]          lamp_state_q;
	logic                acpend_q;
	logic [1:0]          acpend_sel_q;
	logic [15:0]         acpend_val_q;
	logic                ac_we_q;
	logic [1:0]          ac_wsel_q;
	logic [15:0]         ac_wdata_q;
	logic [1:0]          ac_rsel_q;
	logic                mem_req_q;
	logic                mem_we_q;
	logic [14:0]         mem_addr_q;
	logic [15:0]         mem_wdata_q;
	logic [5:0]          boot_cnt_q;
	logic                dev_rd_q;
	logic                start_in_q;
	logic [5:0]          dev_code_q;
	logic                io_reset_q;
	logic [15:0]         sw_rd_q;
	logic                intr_en_q;
	logic [31:0]         prdata_q;
	logic                pready_q;
	logic                pslverr_q;
	logic [31:0]         status;

	assign sw_raw = {sw_chan_start_i, sw_prog_load_i, sw_reset_i,
		sw_mem_step_i, sw_instr_adv_i, sw_continue_i, sw_stop_i,
		sw_start_i, sw_dep_next_i, sw_exam_next_i, sw_deposit_i,
		sw_examine_i, sw_ac_exam_i, sw_ac_dep_i};

	// Two-stage synchroniser and rising-edge detect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sw_meta_q <= '0;
			sw_sync_q <= '0;
			sw_prev_q <= '0;
		end
		else
		begin
			sw_meta_q <= sw_raw;
			sw_sync_q <= sw_meta_q;
			sw_prev_q <= sw_sync_q;
		end
	end

	assign press     = sw_sync_q & ~sw_prev_q;
	assign enabled   = ~key_lock_i & ctrl_q[CTRL_EN_BIT];
	assign idle      = ~run_q && (con_q == C_IDLE);
	assign stop_p    = press[SW_STOP] & enabled;
	assign reset_p   = press[SW_RESET] & enabled;
	assign any_go    = enabled && idle
		&& (|press[SW_CHAN_START:SW_AC_DEP] & ~press[SW_STOP]
		& ~press[SW_RESET]);
	assign boot_last = HAS_BOOT_ROM ? BOOT_ROM_LAST : BOOT_DEV_LAST;
	assign boot_done = (con_q == C_BOOT_WR) && mem_ack_i
		&& (boot_cnt_q == boot_last);
	assign chan_done = (con_q == C_CHAN_WR) && mem_ack_i;

	always_comb
	begin
		dep_hit  = 1'b0;
		exam_hit = 1'b0;
		dep_idx  = 2'd0;
		exam_idx = 2'd0;
		for (int i = NUM_AC - 1; i >= 0; i--)
		begin
			if (press[SW_AC_DEP + i])
			begin
				dep_hit = 1'b1;
				dep_idx = 2'(i);
			end
			if (press[SW_AC_EXAM + i])
			begin
				exam_hit = 1'b1;
				exam_idx = 2'(i);
			end
		end
	end

	assign run_go = (any_go && (press[SW_START] || press[SW_CONTINUE]
		|| press[SW_INSTR_ADV] || press[SW_MEM_STEP]))
		|| boot_done || chan_done;
	assign halt_now = run_q && cpu_cycle_done_i && (cyc_step_q
		|| (stop_pend_q && cpu_next_state_i == CYC_FETCH));

	// Run, stop and step control
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_q       <= 1'b0;
			stop_pend_q <= 1'b0;
			cyc_step_q  <= 1'b0;
			serviced_q  <= 1'b0;
		end
		else if (halt_now)
		begin
			run_q       <= 1'b0;
			stop_pend_q <= 1'b0;
			cyc_step_q  <= 1'b0;
			serviced_q  <= 1'b0;
		end
		else
		begin
			if (run_go)
				run_q <= 1'b1;
			if (stop_p || (any_go && press[SW_INSTR_ADV]))
				stop_pend_q <= 1'b1;
			if ((any_go && press[SW_MEM_STEP]) || (reset_p && run_q))
				cyc_step_q <= 1'b1;
			if (run_q && cpu_cycle_done_i && stop_pend_q
				&& (state_q == CYC_CHANNEL || state_q == CYC_INTR))
				serviced_q <= 1'b1;
		end
	end

	// Next cycle type
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_q <= CYC_FETCH;
		else if (run_q && cpu_cycle_done_i)
			state_q <= cpu_next_state_i;
		else if (any_go && !press[SW_CONTINUE] && !press[SW_INSTR_ADV]
			&& !press[SW_MEM_STEP])
			state_q <= CYC_FETCH;
		else if (boot_done || chan_done)
			state_q <= CYC_FETCH;
	end

	// Console sequencing, memory port and lamp contents
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			con_q        <= C_IDLE;
			pc_q         <= '0;
			instr_pc_q   <= '0;
			lamp_data_q  <= '0;
			lamp_instr_q <= '0;
			mem_req_q    <= 1'b0;
			mem_we_q     <= 1'b0;
			mem_addr_q   <= '0;
			mem_wdata_q  <= '0;
			boot_cnt_q   <= '0;
			dev_rd_q     <= 1'b0;
			start_in_q   <= 1'b0;
			dev_code_q   <= '0;
			ac_rsel_q    <= '0;
		end
		else
		begin
			start_in_q <= 1'b0;
			if (run_q && cpu_cycle_done_i)
			begin
				pc_q <= cpu_pc_i;
				if (state_q == CYC_FETCH)
				begin
					lamp_instr_q <= cpu_instr_i[15:8];
					instr_pc_q   <= pc_q;
				end
				if (FAST_MODEL && cyc_step_q)
					lamp_data_q <= {1'b0, cpu_next_addr_i};
				else if (FAST_MODEL && cpu_instr_done_i && cpu_is_jsr_i)
					lamp_data_q <= {1'b0, 15'(instr_pc_q + 15'd1)};
				else
					lamp_data_q <= cpu_mem_data_i;
				if (halt_now && (serviced_q || state_q == CYC_CHANNEL
					|| state_q == CYC_INTR))
					lamp_instr_q <= '0;
			end
			case (con_q)
			C_IDLE:
			begin
				if (any_go)
				begin
					if (dep_hit)
					begin
						lamp_data_q  <= data_sw_i;
						lamp_instr_q <= '0;
					end
					else if (exam_hit)
					begin
						ac_rsel_q    <= exam_idx;
						lamp_instr_q <= '0;
						con_q        <= C_ACRD;
					end
					else if (press[SW_EXAMINE])
					begin
						pc_q       <= data_sw_i[14:0];
						mem_addr_q <= data_sw_i[14:0];
						mem_we_q   <= 1'b0;
						mem_req_q  <= 1'b1;
						con_q      <= C_MEM;
					end
					else if (press[SW_DEPOSIT])
					begin
						mem_addr_q  <= pc_q;
						mem_wdata_q <= data_sw_i;
						mem_we_q    <= 1'b1;
						mem_req_q   <= 1'b1;
						con_q       <= C_MEM;
					end
					else if (press[SW_EXAM_NEXT] || press[SW_DEP_NEXT])
					begin
						pc_q        <= 15'(pc_q + 15'd1);
						mem_addr_q  <= 15'(pc_q + 15'd1);
						mem_wdata_q <= data_sw_i;
						mem_we_q    <= press[SW_DEP_NEXT];
						mem_req_q   <= 1'b1;
						con_q       <= C_MEM;
					end
					else if (press[SW_START])
						pc_q <= data_sw_i[14:0];
					else if (press[SW_PROG_LOAD])
					begin
						boot_cnt_q <= '0;
						dev_code_q <= data_sw_i[5:0];
						dev_rd_q   <= !HAS_BOOT_ROM;
						con_q      <= C_BOOT_SRC;
					end
					else if (press[SW_CHAN_START])
					begin
						dev_code_q <= data_sw_i[5:0];
						start_in_q <= 1'b1;
						con_q      <= C_CHAN_CMD;
					end
				end
			end
			C_ACRD:
			begin
				lamp_data_q <= ac_rdata_i;
				con_q       <= C_IDLE;
			end
			C_MEM:
			begin
				if (mem_ack_i)
				begin
					mem_req_q   <= 1'b0;
					lamp_data_q <= mem_we_q ? mem_wdata_q
						: mem_rdata_i;
					con_q       <= C_IDLE;
				end
			end
			C_BOOT_SRC:
			begin
				if (HAS_BOOT_ROM || dev_ready_i)
				begin
					dev_rd_q    <= 1'b0;
					mem_addr_q  <= {9'd0, boot_cnt_q};
					mem_wdata_q <= HAS_BOOT_ROM ? rom_data_i : dev_data_i;
					mem_we_q    <= 1'b1;
					mem_req_q   <= 1'b1;
					con_q       <= C_BOOT_WR;
				end
			end
			C_BOOT_WR:
			begin
				if (mem_ack_i)
				begin
					mem_req_q   <= 1'b0;
					lamp_data_q <= mem_wdata_q;
					boot_cnt_q  <= 6'(boot_cnt_q + 6'd1);
					if (boot_done)
					begin
						pc_q  <= HAS_BOOT_ROM ? BOOT_ROM_START
							: BOOT_DEV_START;
						con_q <= C_IDLE;
					end
					else
					begin
						dev_rd_q <= !HAS_BOOT_ROM;
						con_q    <= C_BOOT_SRC;
					end
				end
			end
			C_CHAN_CMD:
			begin
				mem_addr_q  <= CHAN_ADDR;
				mem_wdata_q <= JUMP_SELF_WORD;
				mem_we_q    <= 1'b1;
				mem_req_q   <= 1'b1;
				con_q       <= C_CHAN_WR;
			end
			C_CHAN_WR:
			begin
				if (mem_ack_i)
				begin
					mem_req_q   <= 1'b0;
					lamp_data_q <= mem_wdata_q;
					pc_q        <= CHAN_ADDR;
					con_q       <= C_IDLE;
				end
			end
			default:
				con_q <= C_IDLE;
			endcase
		end
	end

	// Deferred accumulator write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			acpend_q     <= 1'b0;
			acpend_sel_q <= '0;
			acpend_val_q <= '0;
			ac_we_q      <= 1'b0;
			ac_wsel_q    <= '0;
			ac_wdata_q   <= '0;
		end
		else
		begin
			ac_we_q <= 1'b0;
			if (reset_p)
				acpend_q <= 1'b0;
			else if (any_go)
			begin
				if (acpend_q)
				begin
					ac_we_q    <= 1'b1;
					ac_wsel_q  <= acpend_sel_q;
					ac_wdata_q <= acpend_val_q;
				end
				acpend_q <= dep_hit;
				if (dep_hit)
				begin
					acpend_sel_q <= dep_idx;
					acpend_val_q <= data_sw_i;
				end
			end
		end
	end

	// Console reset pulse and program-visible switch register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			io_reset_q <= 1'b0;
			sw_rd_q    <= '0;
			intr_en_q  <= 1'b0;
		end
		else
		begin
			io_reset_q <= reset_p;
			sw_rd_q    <= data_sw_i;
			intr_en_q  <= intr_en_i;
		end
	end

	// State indicator lamps
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lamp_state_q <= '0;
		else
		begin
			lamp_state_q <= '0;
			case (state_q)
			CYC_FETCH:    lamp_state_q[LAMP_FETCH] <= !FAST_MODEL;
			CYC_INDIRECT: lamp_state_q[LAMP_INDIRECT] <= 1'b1;
			CYC_EXECUTE:  lamp_state_q[LAMP_EXECUTE] <= 1'b1;
			CYC_CHANNEL:  lamp_state_q[LAMP_CHANNEL] <= 1'b1;
			CYC_INTR:     lamp_state_q[LAMP_INTR] <= 1'b1;
			default:      lamp_state_q <= '0;
			endcase
		end
	end

	assign status = {22'd0, (con_q != C_IDLE), acpend_q, key_lock_i,
		intr_en_q, run_q, lamp_state_q};

	// APB slave with one wait state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q    <= CTRL_RESET;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (psel_i && penable_i && !pready_q)
		begin
			pready_q  <= 1'b1;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
			case (paddr_i)
			REG_STATUS:    prdata_q <= status;
			REG_LAMP_ADDR: prdata_q <= {17'd0, pc_q};
			REG_LAMP_DATA: prdata_q <= {16'd0, lamp_data_q};
			REG_CTRL:
			begin
				prdata_q <= ctrl_q;
				if (pwrite_i)
					ctrl_q <= {31'd0, pwdata_i[CTRL_EN_BIT]};
			end
			default:       pslverr_q <= 1'b1;
			endcase
		end
		else
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign prdata_o     = prdata_q;
	assign pready_o     = pready_q;
	assign pslverr_o    = pslverr_q;
	assign sw_rd_data_o = sw_rd_q;
	assign cpu_run_o    = run_q;
	assign cpu_state_o  = state_q;
	assign cpu_pc_o     = pc_q;
	assign ac_we_o      = ac_we_q;
	assign ac_wsel_o    = ac_wsel_q;
	assign ac_wdata_o   = ac_wdata_q;
	assign ac_rsel_o    = ac_rsel_q;
	assign mem_req_o    = mem_req_q;
	assign mem_we_o     = mem_we_q;
	assign mem_addr_o   = mem_addr_q;
	assign mem_wdata_o  = mem_wdata_q;
	assign dev_rd_o     = dev_rd_q;
	assign dev_start_in_o = start_in_q;
	assign dev_code_o   = dev_code_q;
	assign rom_addr_o   = boot_cnt_q[4:0];
	assign io_reset_o   = io_reset_q;
	assign intr_en_clear_o = io_reset_q;
	assign supervisor_o = io_reset_q;
	assign rtc_line_o   = io_reset_q;
	assign lamp_addr_o  = pc_q;
	assign lamp_data_o  = lamp_data_q;
	assign lamp_instr_o = lamp_instr_q;
	assign lamp_state_o = lamp_state_q;
	assign lamp_run_o   = run_q;
	assign lamp_intr_en_o = intr_en_q;

endmodule // occ_console

// *** verilog/occ_pkg.sv ***
package occ_pkg;

	// APB register byte offsets
	localparam logic [11:0] REG_STATUS    = 12'h000;
	localparam logic [11:0] REG_LAMP_ADDR = 12'h004;
	localparam logic [11:0] REG_LAMP_DATA = 12'h008;
	localparam logic [11:0] REG_CTRL      = 12'h00C;

	// Control register fields and reset value
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

	// Status register field positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_RUN_BIT   = 5;
	localparam int ST_INTR_EN_BIT = 6;
	localparam int ST_LOCK_BIT  = 7;
	localparam int ST_ACPND_BIT = 8;
	localparam int ST_BUSY_BIT  = 9;

	// Processor cycle types
	typedef enum logic [2:0] {
		CYC_FETCH,
		CYC_INDIRECT,
		CYC_EXECUTE,
		CYC_CHANNEL,
		CYC_INTR
	} occ_cycle_e;

	// Lamp positions for the state indicators
	localparam int LAMP_FETCH    = 0;
	localparam int LAMP_INDIRECT = 1;
	localparam int LAMP_EXECUTE  = 2;
	localparam int LAMP_CHANNEL  = 3;
	localparam int LAMP_INTR     = 4;

	// Momentary switch positions in the press vector
	localparam int SW_AC_DEP     = 0;
	localparam int SW_AC_EXAM    = 4;
	localparam int SW_EXAMINE    = 8;
	localparam int SW_DEPOSIT    = 9;
	localparam int SW_EXAM_NEXT  = 10;
	localparam int SW_DEP_NEXT   = 11;
	localparam int SW_START      = 12;
	localparam int SW_STOP       = 13;
	localparam int SW_CONTINUE   = 14;
	localparam int SW_INSTR_ADV  = 15;
	localparam int SW_MEM_STEP   = 16;
	localparam int SW_RESET      = 17;
	localparam int SW_PROG_LOAD  = 18;
	localparam int SW_CHAN_START = 19;
	localparam int SW_COUNT      = 20;
	localparam int NUM_AC        = 4;

	// Bootstrap and channel start figures
	localparam logic [5:0]  BOOT_DEV_LAST  = 6'd32;
	localparam logic [14:0] BOOT_DEV_START = 15'h0020;
	localparam logic [5:0]  BOOT_ROM_LAST  = 6'd31;
	localparam logic [14:0] BOOT_ROM_START = 15'h0000;
	localparam logic [14:0] CHAN_ADDR      = 15'h00FF;
	localparam logic [15:0] JUMP_SELF_WORD = 16'h00FF;

endpackage
